// File: shared/cer_pkg.sv
// Constants and types shared by the exposure and readout sequencer
package cer_pkg;

   // ==========================================
   // Register map (byte addresses)
   localparam logic [7:0] CER_OFF_CTRL    = 8'h00;
   localparam logic [7:0] CER_OFF_SHUTTER = 8'h04;
   localparam logic [7:0] CER_OFF_GAIN    = 8'h08;
   localparam logic [7:0] CER_OFF_BRIGHT  = 8'h0C;
   localparam logic [7:0] CER_OFF_STATUS  = 8'h10;

   // ==========================================
   // Control register fields
   localparam int CER_CTRL_TRIG_EN = 0;  // Trigger enable
   localparam int CER_CTRL_SINGLE  = 1;  // Single-shot request
   localparam int CER_CTRL_CONT    = 2;  // Continuous-shot request
   localparam int CER_CTRL_VARIANT = 3;  // 0 pixel-memory, 1 shift-register

   // ==========================================
   // Values after reset
   localparam logic [31:0] CER_RST_SHUTTER = 32'h0000_0064;
   localparam logic [7:0]  CER_RST_GAIN    = 8'h10;    // Unity with 4 fraction bits
   localparam logic [11:0] CER_RST_BRIGHT  = 12'h000;

   // ==========================================
   // Frame geometry and sample widths
   localparam int CER_ROWS      = 4;
   localparam int CER_COLS      = 8;
   localparam int CER_ROW_W     = 2;
   localparam int CER_COL_W     = 3;
   localparam int CER_PM_BITS   = 10;
   localparam int CER_SR_BITS   = 12;
   localparam int CER_GAIN_FRAC = 4;
   localparam logic [11:0] CER_PM_MAX = 12'h03FF;
   localparam logic [11:0] CER_SR_MAX = 12'h0FFF;

   // ==========================================
   // Bus answers
   localparam logic [1:0] CER_RESP_OKAY   = 2'b00;
   localparam logic [1:0] CER_RESP_SLVERR = 2'b10;

   // ==========================================
   // State machines
   typedef enum logic [1:0] {
      CER_EXP_IDLE = 2'b00,
      CER_EXP_RUN  = 2'b01,
      CER_EXP_HOLD = 2'b10
   } cer_exp_e;

   typedef enum logic [1:0] {
      CER_RD_IDLE  = 2'b00,
      CER_RD_LOAD  = 2'b01,
      CER_RD_SHIFT = 2'b10
   } cer_rd_e;

endpackage

// File: hw/cer_sequencer.sv
// Exposure start, sensor readout, image buffer and frame transfer
// Summary of operation
// - Rising trigger edge starts exposure, which lasts the programmed shutter time.
// - Readout starts as soon as the exposure time has elapsed; code waits in CER_EXP_HOLD while readout is busy or the write bank is full.
// - Pixel-memory variant may expose the next frame during readout.
// - Pixel-memory readout selects one row at a time onto column lines.
// - Each column has gain stage and converter giving 10 bit samples.
// - Digitized row loads a horizontal register, shifted serially into the buffer.
// - Frame goes to host over transfer bus only after full readout.
// - Buffer decouples readout timing from host acceptance rate.
// - Shift-register variant: pixels to vertical registers, bottom line out horizontally.
// - Shift-register samples pass the gain stage and become 12 bit.
// - Shifting runs at internal data rate until every line is read.
// - Programmable gain and brightness apply to the conversion path.
// - Trigger disabled: triggers ignored, shot requests start exposure.
// - Trigger disabled: exposures start without any trigger event.
// - Single-shot request exposes and transfers exactly one frame.
// - Every shot-controlled frame uses the programmed shutter time.
// - Single-shot request clears itself after its frame is transferred.
// - Setting continuous-shot starts exposure of the first frame.
// - Later continuous frames start automatically, without new requests.
// - Clearing continuous-shot stops new exposures and frame transmission.
// - Continuous operation runs at the highest rate the settings allow.
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module cer_sequencer
   import cer_pkg::*;
(
   input  wire logic                          aclk,            // 125 MHz clock
   input  wire logic                          aresetn,         // Sync reset, active low
   // AXI4-Lite slave
   input  wire logic [7:0]                    s_axi_awaddr,    // Write address
   input  wire logic                          s_axi_awvalid,   // Write address valid
   output logic                               s_axi_awready,   // Write address ready
   input  wire logic [31:0]                   s_axi_wdata,     // Write data
   input  wire logic [3:0]                    s_axi_wstrb,     // Byte enables
   input  wire logic                          s_axi_wvalid,    // Write data valid
   output logic                               s_axi_wready,    // Write data ready
   output logic [1:0]                         s_axi_bresp,     // Write response
   output logic                               s_axi_bvalid,    // Write response valid
   input  wire logic                          s_axi_bready,    // Write response ready
   input  wire logic [7:0]                    s_axi_araddr,    // Read address
   input  wire logic                          s_axi_arvalid,   // Read address valid
   output logic                               s_axi_arready,   // Read address ready
   output logic [31:0]                        s_axi_rdata,     // Read data
   output logic [1:0]                         s_axi_rresp,     // Read response
   output logic                               s_axi_rvalid,    // Read data valid
   input  wire logic                          s_axi_rready,    // Read data ready
   // Trigger pin and sensor
   input  wire logic                          external_trigger_input, // Async trigger pin
   output logic                               exposing,        // Sensor integrating
   output logic                               row_select,      // Pixel-memory row strobe
   output logic [CER_ROW_W-1:0]               row_addr,        // Selected row
   input  wire logic [CER_COLS*CER_PM_BITS-1:0] pm_col_samples, // Column converter outputs
   output logic                               vert_transfer,   // Pixels to vertical regs
   output logic                               line_transfer,   // Bottom line to horizontal
   output logic                               horiz_shift,     // Horizontal shift strobe
   input  wire logic [CER_SR_BITS-1:0]        sr_sample,       // Converter output for shift
   // Frame transfer bus to host
   output logic [15:0]                        ftb_data,        // Pixel word
   output logic                               ftb_valid,       // Word valid
   output logic                               ftb_last,        // Last word of frame
   input  wire logic                          ftb_ready        // Host accepts word
);

   // ==========================================
   // Shared conditioning path: gain, brightness offset, clamp
   function automatic logic [11:0] cond_px(input logic [11:0] raw, input logic [7:0] gain,
                                            input logic [11:0] bright, input logic [11:0] maxv);
      logic [20:0] prod;
      logic [20:0] sum;
      prod = 21'(raw) * 21'(gain);
      sum  = (prod >> CER_GAIN_FRAC) + 21'(bright);
      return (sum > 21'(maxv)) ? maxv : sum[11:0];
   endfunction

   // ==========================================
   // Registers
   logic        trig_en_ff, single_ff, cont_ff, variant_ff, ss_pend_ff;
   logic [31:0] shutter_ff;
   logic [7:0]  gain_ff;
   logic [11:0] bright_ff;
   logic        bvalid_ff, rvalid_ff;
   logic [1:0]  bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;
   logic        trig_s1_ff, trig_s2_ff, trig_s3_ff;
   cer_exp_e    exp_ff;
   logic [31:0] exp_cnt_ff;
   cer_rd_e     rd_ff;
   logic [CER_ROW_W-1:0] row_ff;
   logic [CER_COL_W-1:0] col_ff, wcol_ff;
   logic [11:0] hreg_ff [CER_COLS];
   logic        row_sel_ff, vxfer_ff, lxfer_ff, hshift_ff;
   logic [1:0]  full_ff;
   logic        wr_bank_ff, tx_bank_ff, tx_busy_ff;
   logic [CER_ROW_W+CER_COL_W-1:0] tx_idx_ff;
   logic [15:0] ftb_data_ff;
   logic        ftb_last_ff;
   logic [15:0] frames_ff;
   logic [11:0] mem [2*CER_ROWS*CER_COLS];

   // ==========================================
   // Bus decode
   wire wr_go   = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
   wire rd_go   = s_axi_arvalid & ~rvalid_ff;
   wire wr_ctrl = wr_go & (s_axi_awaddr == CER_OFF_CTRL) & s_axi_wstrb[0];
   wire wr_shut = wr_go & (s_axi_awaddr == CER_OFF_SHUTTER);
   wire wr_gain = wr_go & (s_axi_awaddr == CER_OFF_GAIN) & s_axi_wstrb[0];
   wire wr_brt  = wr_go & (s_axi_awaddr == CER_OFF_BRIGHT);
   wire wr_hit  = (s_axi_awaddr == CER_OFF_CTRL) | (s_axi_awaddr == CER_OFF_SHUTTER) |
                  (s_axi_awaddr == CER_OFF_GAIN) | (s_axi_awaddr == CER_OFF_BRIGHT) |
                  (s_axi_awaddr == CER_OFF_STATUS);
   wire ss_set  = wr_ctrl & s_axi_wdata[CER_CTRL_SINGLE];
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = rd_go;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rresp   = rresp_ff;
   assign s_axi_rdata   = rdata_ff;

   // Read multiplexer
   logic [31:0] rd_mux;
   logic        rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      case (s_axi_araddr)
         CER_OFF_CTRL:    rd_mux = {28'h000_0000, variant_ff, cont_ff, single_ff, trig_en_ff};
         CER_OFF_SHUTTER: rd_mux = shutter_ff;
         CER_OFF_GAIN:    rd_mux = {24'h00_0000, gain_ff};
         CER_OFF_BRIGHT:  rd_mux = {20'h0_0000, bright_ff};
         CER_OFF_STATUS:  rd_mux = {frames_ff, 7'h00, tx_busy_ff, full_ff, rd_ff, exp_ff,
                                    ss_pend_ff, 1'b0};
         default: begin
            rd_mux = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   // ==========================================
   // Exposure start decision
   wire trig_edge  = trig_s2_ff & ~trig_s3_ff;
   wire want_shot  = (single_ff & ss_pend_ff) | cont_ff;
   wire start_src  = trig_en_ff ? (trig_edge & want_shot) : want_shot;
   wire rd_free    = (rd_ff == CER_RD_IDLE) & ~full_ff[wr_bank_ff];
   wire exp_allow  = variant_ff ? (rd_ff == CER_RD_IDLE) : 1'b1;
   wire exp_start  = (exp_ff == CER_EXP_IDLE) & exp_allow & start_src;
   wire exp_done   = (exp_ff == CER_EXP_RUN) & (exp_cnt_ff + 32'h0000_0001 >= shutter_ff);
   wire rd_start   = (exp_done | (exp_ff == CER_EXP_HOLD)) & rd_free;
   assign exposing = (exp_ff == CER_EXP_RUN);

   // ==========================================
   // Readout pixel path
   wire pix_wr   = variant_ff ? hshift_ff : (rd_ff == CER_RD_SHIFT);
   wire [11:0] sr_px = cond_px(sr_sample, gain_ff, bright_ff, CER_SR_MAX);
   wire [11:0] pix_d = variant_ff ? sr_px : hreg_ff[0];
   wire row_end  = pix_wr & (wcol_ff == CER_COL_W'(CER_COLS - 1));
   wire frm_end  = row_end & (row_ff == CER_ROW_W'(CER_ROWS - 1));
   wire [CER_ROW_W+CER_COL_W:0] wr_addr = {wr_bank_ff, row_ff, wcol_ff};
   assign row_select    = row_sel_ff;
   assign row_addr      = row_ff;
   assign vert_transfer = vxfer_ff;
   assign line_transfer = lxfer_ff;
   assign horiz_shift   = hshift_ff;

   // Horizontal register: parallel load of a row or serial shift
   logic [11:0] nxt_hreg [CER_COLS];
   always_comb begin
      for (int i = 0; i < CER_COLS; i++) begin
         if (rd_ff == CER_RD_LOAD && !variant_ff) begin
            nxt_hreg[i] = cond_px({2'b00, pm_col_samples[i*CER_PM_BITS +: CER_PM_BITS]},
                                  gain_ff, bright_ff, CER_PM_MAX);
         end else if (pix_wr && !variant_ff) begin
            nxt_hreg[i] = (i == CER_COLS - 1) ? 12'h000 : hreg_ff[(i + 1) % CER_COLS];
         end else begin
            nxt_hreg[i] = hreg_ff[i];
         end
      end
   end

   // ==========================================
   // Transfer side
   wire tx_ok    = single_ff | cont_ff;
   wire tx_begin = ~tx_busy_ff & full_ff[tx_bank_ff] & tx_ok;
   wire tx_take  = tx_busy_ff & ftb_ready;
   wire tx_end   = tx_take & ftb_last_ff;
   wire flush    = ~tx_ok & ~tx_busy_ff;
   wire [CER_ROW_W+CER_COL_W-1:0] tx_next = tx_begin ? '0 : tx_idx_ff + 1'b1;
   assign ftb_data  = ftb_data_ff;
   assign ftb_valid = tx_busy_ff;
   assign ftb_last  = ftb_last_ff;

   // Buffer occupancy, set by readout and cleared by transfer
   logic [1:0] nxt_full;
   always_comb begin
      nxt_full = full_ff;
      if (tx_end) nxt_full[tx_bank_ff] = 1'b0;
      if (flush) nxt_full = 2'b00;
      if (frm_end) nxt_full[wr_bank_ff] = 1'b1;
   end

   // ==========================================
   // Register file and bus answers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trig_en_ff <= 1'b0;
         cont_ff    <= 1'b0;
         variant_ff <= 1'b0;
         shutter_ff <= CER_RST_SHUTTER;
         gain_ff    <= CER_RST_GAIN;
         bright_ff  <= CER_RST_BRIGHT;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= CER_RESP_OKAY;
         rvalid_ff  <= 1'b0;
         rresp_ff   <= CER_RESP_OKAY;
         rdata_ff   <= 32'h0000_0000;
      end else begin
         if (wr_ctrl) begin
            trig_en_ff <= s_axi_wdata[CER_CTRL_TRIG_EN];
            cont_ff    <= s_axi_wdata[CER_CTRL_CONT];
            variant_ff <= s_axi_wdata[CER_CTRL_VARIANT];
         end
         for (int b = 0; b < 4; b++) begin
            if (wr_shut && s_axi_wstrb[b]) shutter_ff[b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
         end
         if (wr_gain) gain_ff <= s_axi_wdata[7:0];
         if (wr_brt && s_axi_wstrb[0]) bright_ff[7:0] <= s_axi_wdata[7:0];
         if (wr_brt && s_axi_wstrb[1]) bright_ff[11:8] <= s_axi_wdata[11:8];
         if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_hit ? CER_RESP_OKAY : CER_RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
         if (rd_go) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_mux;
            rresp_ff  <= rd_hit ? CER_RESP_OKAY : CER_RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   // Single-shot request: software set wins over self clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         single_ff  <= 1'b0;
         ss_pend_ff <= 1'b0;
      end else begin
         if (ss_set) single_ff <= 1'b1;
         else if (tx_end) single_ff <= 1'b0;
         else if (wr_ctrl) single_ff <= 1'b0;
         if (ss_set) ss_pend_ff <= 1'b1;
         else if (exp_start & ~cont_ff) ss_pend_ff <= 1'b0;
      end
   end

   // Trigger pin synchroniser and edge history
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trig_s1_ff <= 1'b0;
         trig_s2_ff <= 1'b0;
         trig_s3_ff <= 1'b0;
      end else begin
         trig_s1_ff <= external_trigger_input;
         trig_s2_ff <= trig_s1_ff;
         trig_s3_ff <= trig_s2_ff;
      end
   end

   // ==========================================
   // Exposure timer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         exp_ff     <= CER_EXP_IDLE;
         exp_cnt_ff <= 32'h0000_0000;
      end else begin
         case (exp_ff)
            CER_EXP_IDLE: begin
               exp_cnt_ff <= 32'h0000_0000;
               if (exp_start) exp_ff <= CER_EXP_RUN;
            end
            CER_EXP_RUN: begin
               exp_cnt_ff <= exp_cnt_ff + 32'h0000_0001;
               if (exp_done) exp_ff <= rd_start ? CER_EXP_IDLE : CER_EXP_HOLD;
            end
            CER_EXP_HOLD: begin
               if (rd_start) exp_ff <= CER_EXP_IDLE;
            end
            default: exp_ff <= CER_EXP_IDLE;
         endcase
      end
   end

   // ==========================================
   // Readout sequencer for both sensor variants
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_ff      <= CER_RD_IDLE;
         row_ff     <= '0;
         col_ff     <= '0;
         wcol_ff    <= '0;
         row_sel_ff <= 1'b0;
         vxfer_ff   <= 1'b0;
         lxfer_ff   <= 1'b0;
         hshift_ff  <= 1'b0;
      end else begin
         row_sel_ff <= 1'b0;
         vxfer_ff   <= 1'b0;
         lxfer_ff   <= 1'b0;
         hshift_ff  <= 1'b0;
         case (rd_ff)
            CER_RD_IDLE: begin
               row_ff <= '0;
               if (rd_start) begin
                  rd_ff    <= CER_RD_LOAD;
                  vxfer_ff <= variant_ff;
               end
            end
            CER_RD_LOAD: begin
               row_sel_ff <= ~variant_ff;
               lxfer_ff   <= variant_ff;
               col_ff     <= '0;
               wcol_ff    <= '0;
               rd_ff      <= CER_RD_SHIFT;
            end
            CER_RD_SHIFT: begin
               if (variant_ff && col_ff != CER_COL_W'(CER_COLS - 1) | ~hshift_ff & ~pix_wr) begin
                  hshift_ff <= ~row_end;
               end
               if (hshift_ff) col_ff <= col_ff + 1'b1;
               if (pix_wr) wcol_ff <= wcol_ff + 1'b1;
               if (row_end) begin
                  hshift_ff <= 1'b0;
                  row_ff    <= row_ff + 1'b1;
                  rd_ff     <= frm_end ? CER_RD_IDLE : CER_RD_LOAD;
               end
            end
            default: rd_ff <= CER_RD_IDLE;
         endcase
      end
   end

   // Horizontal register and image buffer writes
   always_ff @(posedge aclk) begin
      hreg_ff <= nxt_hreg;
      if (pix_wr) mem[wr_addr] <= pix_d;
   end

   // ==========================================
   // Bank bookkeeping and frame transfer to host
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         full_ff     <= 2'b00;
         wr_bank_ff  <= 1'b0;
         tx_bank_ff  <= 1'b0;
         tx_busy_ff  <= 1'b0;
         tx_idx_ff   <= '0;
         ftb_data_ff <= 16'h0000;
         ftb_last_ff <= 1'b0;
         frames_ff   <= 16'h0000;
      end else begin
         full_ff <= nxt_full;
         if (frm_end) wr_bank_ff <= ~wr_bank_ff;
         if (flush) tx_bank_ff <= wr_bank_ff ^ frm_end;
         if (tx_begin | (tx_take & ~ftb_last_ff)) begin
            tx_busy_ff  <= 1'b1;
            tx_idx_ff   <= tx_next;
            ftb_data_ff <= {4'h0, mem[{tx_bank_ff, tx_next}]};
            ftb_last_ff <= (tx_next == '1);
         end else if (tx_end) begin
            tx_busy_ff  <= 1'b0;
            ftb_last_ff <= 1'b0;
            tx_bank_ff  <= ~tx_bank_ff;
            frames_ff   <= frames_ff + 16'h0001;
         end
      end
   end

endmodule

`default_nettype wire

// File: sim/cer_sequencer_asserts.sv
// Port-level checks of the sequencer
`timescale 1ns/1ps
`default_nettype none
module cer_sequencer_asserts
   import cer_pkg::*;
(
   input wire logic        aclk,          // Clock
   input wire logic        aresetn,       // Reset, low
   input wire logic        s_axi_awvalid, // Aw valid
   input wire logic        s_axi_awready, // Aw ready
   input wire logic        s_axi_bvalid,  // B valid
   input wire logic        s_axi_arvalid, // Ar valid
   input wire logic        s_axi_arready, // Ar ready
   input wire logic        s_axi_rvalid,  // R valid
   input wire logic        row_select,    // Row strobe
   input wire logic        line_transfer, // Line strobe
   input wire logic        horiz_shift,   // Shift strobe
   input wire logic [15:0] ftb_data,      // Pixel word
   input wire logic        ftb_valid,     // Word valid
   input wire logic        ftb_last,      // Last word
   input wire logic        ftb_ready      // Host accepts
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================
   // Sensor strobes
   AST_ROW_GAP: assert property (row_select |=> !row_select [*8])
      else $error("row strobes too close");
   AST_LINE_GAP: assert property (line_transfer |=> !line_transfer [*8])
      else $error("line strobes too close");
   AST_VARIANT: assert property (!(row_select && (line_transfer || horiz_shift)))
      else $error("both sensor variants strobed");
   // ==========================================
   // Frame transfer bus
   AST_FTB_HOLD: assert property (ftb_valid && !ftb_ready |=> ftb_valid && $stable(ftb_data)
      && $stable(ftb_last))
      else $error("stalled word changed");
   AST_LAST_VALID: assert property (ftb_last |-> ftb_valid)
      else $error("end marker without word");
   AST_LAST_GAP: assert property (ftb_valid && ftb_ready && ftb_last |=> !ftb_last)
      else $error("end markers back to back");
   // ==========================================
   // Register bus answers
   AST_B_ANS: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
      else $error("write response late");
   AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
endmodule
bind cer_sequencer cer_sequencer_asserts u_chk (.*);
`default_nettype wire

// File: sim/cer_host_model.sv
// Host end of the frame transfer bus
`timescale 1ns/1ps
`default_nettype none
module cer_host_model (
   input  wire logic        aclk,      // Clock
   input  wire logic        aresetn,   // Reset, low
   input  wire logic        stall_en,  // Throttle
   input  wire logic [15:0] ftb_data,  // Pixel word
   input  wire logic        ftb_valid, // Word valid
   input  wire logic        ftb_last,  // Last word
   output logic             ftb_ready, // Accept
   output logic [15:0]      frames,    // Frames taken
   output logic [15:0]      last_errs  // Bad end markers
);
   logic [15:0] pix [32];
   logic [4:0]  wcnt;
   logic [1:0]  pace;
   // Accept always, or one cycle in four when throttled; store words
   always @(posedge aclk) begin
      if (!aresetn) begin
         pace <= 2'h0;
         ftb_ready <= 1'b0;
         wcnt <= 5'h00;
         frames <= 16'h0000;
         last_errs <= 16'h0000;
      end else begin
         pace <= pace + 2'h1;
         ftb_ready <= !stall_en || (pace == 2'h0);
         if (ftb_valid && ftb_ready) begin
            pix[wcnt] <= ftb_data;
            wcnt <= ftb_last ? 5'h00 : wcnt + 5'h01;
            frames <= frames + 16'(ftb_last);
            last_errs <= last_errs + 16'(ftb_last != (wcnt == 5'h1F));
         end
      end
   end
endmodule
`default_nettype wire

// File: sim/cer_sequencer_tb.sv
// Self-checking bench of the sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
`define WAITC(c, n) begin for (int k = 0; k < (n) && !(c); k++) @(posedge aclk); \
   if (!(c)) begin miscompares++; $display("BAD wait exp 1 got 0"); give_verdict(); end end
module cer_sequencer_tb
   import cer_pkg::*;
;
   typedef struct packed {logic [7:0] a; logic w; logic [31:0] d, q; logic [1:0] r;} cer_row_s;
   logic        aclk = 1'b0, aresetn = 1'b0, stall_en = 1'b0, external_trigger_input = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ovl = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        exposing, row_select, vert_transfer, line_transfer, horiz_shift;
   logic        ftb_valid, ftb_last, ftb_ready;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic [1:0]  row_addr;
   logic [79:0] pm_col_samples;
   logic [11:0] sr_sample;
   logic [15:0] ftb_data, frames, last_errs, f0, e0, expc = 16'h0000;
   logic [4:0]  shn = 5'h00;
   int          miscompares = 0, compares = 0;
   cer_row_s    rows [8] = '{
      '{CER_OFF_CTRL, 1'b0, 32'h0000_0000, 32'h0000_0000, CER_RESP_OKAY},
      '{CER_OFF_SHUTTER, 1'b0, 32'h0000_0000, CER_RST_SHUTTER, CER_RESP_OKAY},
      '{CER_OFF_GAIN, 1'b0, 32'h0000_0000, 32'(CER_RST_GAIN), CER_RESP_OKAY},
      '{CER_OFF_BRIGHT, 1'b0, 32'h0000_0000, 32'(CER_RST_BRIGHT), CER_RESP_OKAY},
      '{CER_OFF_STATUS, 1'b0, 32'h0000_0000, 32'h0000_0000, CER_RESP_OKAY},
      '{CER_OFF_SHUTTER, 1'b1, 32'h0000_0014, 32'h0000_0014, CER_RESP_OKAY},
      '{CER_OFF_BRIGHT, 1'b1, 32'h0000_0003, 32'h0000_0003, CER_RESP_OKAY},
      '{8'h14, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000, CER_RESP_SLVERR}};
   cer_sequencer  u_dut (.*);
   cer_host_model u_host (.*);
   initial forever #4 aclk = ~aclk;
   function automatic logic [9:0] pm_raw(input int r, input int c);
      return (r == 3 && c == 7) ? 10'h3FE : 10'(r * 8 + c + 1);
   endfunction
   function automatic logic [11:0] sr_raw(input int k);
      return (k == 31) ? 12'hFFE : 12'(256 + k);
   endfunction
   function automatic logic [15:0] exp_pix(input logic sr, input int j);
      int v;
      int top;
      v = 3 + (sr ? int'(sr_raw(j)) : int'(pm_raw(j / 8, j % 8)));
      top = sr ? int'(CER_SR_MAX) : int'(CER_PM_MAX);
      return 16'((v > top) ? top : v);
   endfunction
   // Converters answer the selected row and the shift count
   always_comb begin
      for (int c = 0; c < 8; c++) pm_col_samples[c*10 +: 10] = pm_raw(int'(row_addr), c);
   end
   assign sr_sample = sr_raw(int'(shn));
   // Shift count, exposure time and overlap monitors, frozen during reset
   always @(posedge aclk) if (aresetn) begin
      shn <= vert_transfer ? 5'h00 : shn + 5'(horiz_shift);
      expc <= expc + 16'(exposing);
      ovl <= ovl | (exposing & row_select);
   end
   task automatic give_verdict();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      `WAITC(s_axi_awready && s_axi_wready, 50)
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      @(posedge aclk);
      `WAITC(s_axi_bvalid, 50)
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      `WAITC(s_axi_arready, 50)
      s_axi_arvalid <= 1'b0;
      @(posedge aclk);
      `WAITC(s_axi_rvalid, 50)
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic chk_frame(input logic sr);
      for (int j = 0; j < 32; j++) `CHK("pixel", exp_pix(sr, j), u_host.pix[j])
      `CHK("end marker", 16'h0000, last_errs)
   endtask
   task automatic shoot(input logic [31:0] ctrl, input logic sr);
      f0 = frames;
      e0 = expc;
      axi_wr(CER_OFF_CTRL, ctrl, rs);
      `WAITC(frames == f0 + 16'h0001, 3000)
      repeat (400) @(posedge aclk);
      `CHK("one frame", f0 + 16'h0001, frames)
      `CHK("exposure time", e0 + 16'h0014, expc)
      chk_frame(sr);
      axi_rd(CER_OFF_CTRL, rd, rs);
      `CHK("single cleared", 1'b0, rd[CER_CTRL_SINGLE])
   endtask
   task automatic pulse_trig();
      external_trigger_input <= 1'b1;
      repeat (130) @(posedge aclk);
      external_trigger_input <= 1'b0;
      repeat (10) @(posedge aclk);
   endtask
   // Main sequence
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      `CHK("idle", 4'h0, {s_axi_bvalid, s_axi_rvalid, ftb_valid, exposing})
      foreach (rows[i]) begin
         if (rows[i].w) begin
            axi_wr(rows[i].a, rows[i].d, rs);
            `CHK("bresp", rows[i].r, rs)
         end
         axi_rd(rows[i].a, rd, rs);
         `CHK("rdata", rows[i].q, rd)
         `CHK("rresp", rows[i].r, rs)
      end
      $display("test registers done");
      shoot(32'h0000_0002, 1'b0);
      stall_en <= 1'b1;
      shoot(32'h0000_000A, 1'b1);
      stall_en <= 1'b0;
      $display("test single shots done");
      axi_wr(CER_OFF_SHUTTER, 32'h0000_012C, rs);
      e0 = expc;
      f0 = frames;
      pulse_trig();
      `CHK("no request", e0, expc)
      axi_wr(CER_OFF_CTRL, 32'h0000_0005, rs);
      repeat (30) @(posedge aclk);
      `CHK("waits for edge", e0, expc)
      pulse_trig();
      repeat (20) @(posedge aclk);
      pulse_trig();
      `WAITC(frames == f0 + 16'h0001, 3000)
      repeat (400) @(posedge aclk);
      `CHK("trigger exposure", e0 + 16'h012C, expc)
      `CHK("trigger frames", f0 + 16'h0001, frames)
      $display("test trigger done");
      f0 = frames;
      axi_wr(CER_OFF_CTRL, 32'h0000_0004, rs);
      `WAITC(frames == f0 + 16'h0003, 5000)
      `CHK("overlap", 1'b1, ovl)
      chk_frame(1'b0);
      axi_wr(CER_OFF_CTRL, 32'h0000_0000, rs);
      repeat (1000) @(posedge aclk);
      f0 = frames;
      e0 = expc;
      repeat (1500) @(posedge aclk);
      `CHK("stopped frames", f0, frames)
      `CHK("stopped exposure", e0, expc)
      $display("test continuous done");
      give_verdict();
   end
endmodule
`default_nettype wire
